// ---- lcl_pkg.sv ----
/*
  Shared constants for the load cell command link: command codes, handshake
  status bits, transfer lengths, reset values, timing and state types.
  Assumes a single 250 MHz clock domain for every user of the package.
*/
package lcl_pkg;

  // Timing
  localparam int unsigned CLK_MHZ      = 250;
  localparam int unsigned TIMEOUT_US   = 750;
  // Longest wait rounds down to whole cycles
  localparam int unsigned TIMEOUT_CYC  = TIMEOUT_US * CLK_MHZ;

  // Command codes, channel in the two low bits
  localparam logic [7:0] CMD_BASE_MASK = 8'hfc;
  localparam logic [7:0] CMD_RD_PRESET = 8'h60;
  localparam logic [7:0] CMD_WR_PRESET = 8'h64;
  localparam logic [7:0] CMD_RD_CAL    = 8'h68;
  localparam logic [7:0] CMD_WR_CAL    = 8'h6c;
  localparam logic [7:0] XFER_OK_CODE  = 8'h00;

  // Transfer lengths in bytes
  localparam logic [4:0] XFER_BYTES    = 5'h10;
  localparam logic [4:0] ADDR_BYTES    = 5'h01;

  // Port select and status bit positions
  localparam logic       PORT_DATA     = 1'b0;
  localparam logic       PORT_STATUS   = 1'b1;
  localparam int         IBF_BIT       = 0;
  localparam int         OBF_BIT       = 1;

  // Calibration record layout, least significant byte first
  localparam int         CAL_SCALE_LSB = 0;
  localparam int         CAL_GAIN_LSB  = 32;
  localparam int         CAL_TARE_LSB  = 64;
  localparam int         CAL_REF_LSB   = 96;
  localparam int         FRAC_BITS     = 16;

  // Reset values
  localparam logic [127:0] PRESET_RST  = 128'h0;
  localparam logic [127:0] CAL_RST     = 128'h0;
  localparam logic [7:0]   BUS_ADDR_RST = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SEND,
    ST_RECV
  } lcl_state_type;

  typedef enum logic [2:0] {
    OP_RD_PRESET,
    OP_WR_PRESET,
    OP_RD_CAL,
    OP_WR_CAL,
    OP_BUS_ADDR
  } lcl_op_type;

endpackage

// ---- lcl_sync.sv ----
/*
  Three-stage pin synchroniser with agreement filter.
  Assumes the inputs are asynchronous to clk; the output changes only when
  the second and third stages agree, or for the rstVal load on the first edge after reset.
*/
`timescale 1ns/1ps
module lcl_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pinIn,
  input  wire logic [WIDTH-1:0] rstVal,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;
  logic [WIDTH-1:0] stage3_ff;
  logic [WIDTH-1:0] stable_ff;
  logic             agree;

  // Stage one is read only by stage two, against metastability
  assign agree = (stage2_ff == stage3_ff);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1_ff <= '1;
      stage2_ff <= '1;
      stage3_ff <= '1;
    end else begin
      stage1_ff <= pinIn;
      stage2_ff <= stage1_ff;
      stage3_ff <= stage2_ff;
    end
  end

  // Strobes idle high, so reset is loaded on the first edge after release
  logic started_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      started_ff <= 1'b0;
      stable_ff  <= '1;
    end else begin
      started_ff <= 1'b1;
      if (!started_ff) begin
        stable_ff <= rstVal;
      end else if (agree) begin
        stable_ff <= stage3_ff;
      end
    end
  end

  assign syncOut = stable_ff;

endmodule // lcl_sync

// ---- lcl_weight.sv ----
/*
  Two-stage weight pipeline: scale * gain * (raw - (tare - ref)).
  Assumes scale and gain are signed fixed point with FRAC_BITS fraction bits
  and that start is a one-cycle pulse on clk.
*/
`timescale 1ns/1ps
module lcl_weight
  import lcl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        start,
  input  wire logic [23:0] rawIn,
  input  wire logic [31:0] scaleIn,
  input  wire logic [31:0] gainIn,
  input  wire logic [31:0] tareIn,
  input  wire logic [31:0] refIn,
  output logic      [31:0] weight_ff,
  output logic             valid_ff
);

  logic signed [63:0] gainProd;
  logic signed [31:0] zeroPoint;
  logic signed [31:0] diff;
  logic signed [31:0] gainQ_ff;
  logic signed [31:0] diff_ff;
  logic               stage1_ff;
  logic signed [63:0] finalProd;

  // Zero equals tare minus reference
  assign zeroPoint = $signed(tareIn - refIn);
  assign diff      = $signed({8'h00, rawIn}) - zeroPoint;
  assign gainProd  = $signed(scaleIn) * $signed(gainIn);
  assign finalProd = gainQ_ff * diff_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gainQ_ff  <= '0;
      diff_ff   <= '0;
      stage1_ff <= 1'b0;
      weight_ff <= '0;
      valid_ff  <= 1'b0;
    end else begin
      stage1_ff <= start;
      valid_ff  <= stage1_ff;
      if (start) begin
        gainQ_ff <= gainProd[FRAC_BITS+31:FRAC_BITS];
        diff_ff  <= diff;
      end
      if (stage1_ff) begin
        weight_ff <= finalProd[FRAC_BITS+31:FRAC_BITS];
      end
    end
  end

endmodule // lcl_weight

// ---- lcl_link.sv ----
/*
  Command link between a host bus port and the load cell controller core:
  byte data port with input and output buffer full flags, command decode,
  preset and calibration transfers, timeout abort and the weight pipeline.
  Assumes host strobes and data arrive asynchronously on pins, and that
  measTick is a one-cycle pulse on clk once per measurement cycle.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module lcl_link
  import lcl_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC,
  parameter logic [7:0]  RESET_CMD      = 8'hf0,
  parameter logic [7:0]  ADDR_CMD       = 8'hf4
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         ioWrN,
  input  wire logic         ioRdN,
  input  wire logic         ioAddr,
  input  wire logic [7:0]   ioDataIn,
  output logic      [7:0]   ioDataOut_ff,
  output logic              ioDataOe_ff,
  input  wire logic         measTick,
  input  wire logic [1:0]   measChan,
  input  wire logic [23:0]  measRaw,
  output logic      [31:0]  weightOut,
  output logic              weightValid,
  output logic      [127:0] presetsOut_ff,
  output logic      [7:0]   busAddr_ff,
  output logic              nvmSave_ff,
  output logic              nvmIsCal_ff,
  output logic      [1:0]   nvmChan_ff,
  output logic              restartReq_ff
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [10:0]        pinRaw;
  logic [10:0]        pinSync;
  logic               wrNS;
  logic               rdNS;
  logic               addrS;
  logic [7:0]         dinS;
  logic               prevWrN_ff;
  logic               prevRdN_ff;
  logic               hostWrDone;
  logic               hostRdDone;

  logic [7:0]         inLatch_ff;
  logic [7:0]         outLatch_ff;
  logic               ibf_ff;
  logic               obf_ff;
  logic               nxt_ibf;
  logic               nxt_obf;
  logic [7:0]         statusByte;

  lcl_state_type      state_ff;
  lcl_state_type      nxt_state;
  lcl_op_type         op_ff;
  lcl_op_type         nxt_op;
  logic [1:0]         chan_ff;
  logic [1:0]         nxt_chan;
  logic [4:0]         idx_ff;
  logic [4:0]         nxt_idx;
  logic [31:0]        timer_ff;
  logic [127:0]       shadow_ff;
  logic [127:0]       calMem_ff [4];

  logic [7:0]         cmdBase;
  logic [1:0]         cmdChan;
  logic               pollHit;
  logic               devTake;
  logic               devPut;
  logic [7:0]         putByte;
  logic               doAbort;
  logic               doReset;
  logic               doCommit;
  logic               waiting;
  logic               timedOut;
  logic [4:0]         xferLen;
  logic               isWriteOp;
  logic               lastRecv;
  logic [127:0]       txVec;
  logic [7:0]         txByte;
  logic [127:0]       measCal;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte select, least significant byte first
  function automatic logic [7:0] byteOf(input logic [127:0] vec, input logic [4:0] idx);
    byteOf = vec[{idx[3:0], 3'h0} +: 8];
  endfunction

  function automatic logic isCmd(input logic [7:0] base, input logic [7:0] code);
    isCmd = (base == (code & CMD_BASE_MASK));
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pinRaw = {ioWrN, ioRdN, ioAddr, ioDataIn};

  lcl_sync #(.WIDTH(11)) lcl_sync_inst (
    .clk     (clk),
    .nrst    (nrst),
    .pinIn   (pinRaw),
    .rstVal  (11'h700),
    .syncOut (pinSync)
  );

  assign wrNS  = pinSync[10];
  assign rdNS  = pinSync[9];
  assign addrS = pinSync[8];
  assign dinS  = pinSync[7:0];

  // Trailing edges of the host strobes on the data port address
  assign hostWrDone = wrNS & ~prevWrN_ff & (addrS == PORT_DATA);
  assign hostRdDone = rdNS & ~prevRdN_ff & (addrS == PORT_DATA);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prevWrN_ff <= 1'b1;
      prevRdN_ff <= 1'b1;
    end else begin
      prevWrN_ff <= wrNS;
      prevRdN_ff <= rdNS;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Handshake flags and host read drive
  // A host write wins over the device take and an abort; a device put wins over a host read
  assign nxt_ibf = hostWrDone ? 1'b1 : ((devTake | doAbort | doReset) ? 1'b0 : ibf_ff);
  assign nxt_obf = devPut ? 1'b1 : ((hostRdDone | doAbort | doReset) ? 1'b0 : obf_ff);

  assign statusByte = {6'h00, obf_ff, ibf_ff};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ibf_ff      <= 1'b0;
      obf_ff      <= 1'b0;
      inLatch_ff  <= 8'h00;
      outLatch_ff <= 8'h00;
    end else begin
      ibf_ff <= nxt_ibf;
      obf_ff <= nxt_obf;
      // Writing while the flag is set overwrites unread data
      if (hostWrDone) begin
        inLatch_ff <= dinS;
      end
      if (devPut) begin
        outLatch_ff <= putByte;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ioDataOe_ff  <= 1'b0;
      ioDataOut_ff <= 8'h00;
    end else begin
      ioDataOe_ff  <= ~rdNS;
      ioDataOut_ff <= (addrS == PORT_STATUS) ? statusByte : outLatch_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Command decode
  assign cmdBase = inLatch_ff & CMD_BASE_MASK;
  assign cmdChan = inLatch_ff[1:0];
  assign pollHit = (state_ff == ST_IDLE) & measTick & ibf_ff;

  assign isWriteOp = (op_ff == OP_WR_PRESET) | (op_ff == OP_WR_CAL) | (op_ff == OP_BUS_ADDR);
  assign xferLen   = (op_ff == OP_BUS_ADDR) ? ADDR_BYTES : XFER_BYTES;
  assign lastRecv  = (idx_ff == xferLen - 5'h01);

  assign txVec  = (op_ff == OP_RD_PRESET) ? presetsOut_ff : calMem_ff[chan_ff];
  assign txByte = byteOf(txVec, idx_ff);

  // Waiting on the host: output flag still set, or input flag still clear
  assign waiting  = ((state_ff == ST_SEND) & obf_ff) | ((state_ff == ST_RECV) & ~ibf_ff);
  assign timedOut = waiting & (timer_ff >= TIMEOUT_CYCLES - 1);
  assign doAbort  = timedOut;
  assign doReset  = pollHit & isCmd(cmdBase, RESET_CMD);

  //////////////////////////////////////////////////////////////////////////////
  // Link sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_op    = op_ff;
    nxt_chan  = chan_ff;
    nxt_idx   = idx_ff;
    devTake   = 1'b0;
    devPut    = 1'b0;
    putByte   = txByte;
    doCommit  = 1'b0;
    unique case (state_ff)
      ST_IDLE: begin
        if (pollHit) begin
          devTake  = 1'b1;
          nxt_idx  = 5'h00;
          nxt_chan = cmdChan;
          if (isCmd(cmdBase, ADDR_CMD)) begin
            nxt_op    = OP_BUS_ADDR;
            nxt_state = ST_RECV;
          end else if (isCmd(cmdBase, CMD_RD_PRESET)) begin
            nxt_op    = OP_RD_PRESET;
            nxt_state = ST_SEND;
          end else if (isCmd(cmdBase, CMD_WR_PRESET)) begin
            nxt_op    = OP_WR_PRESET;
            nxt_state = ST_RECV;
          end else if (cmdBase == CMD_RD_CAL) begin
            nxt_op    = OP_RD_CAL;
            nxt_state = ST_SEND;
          end else if (cmdBase == CMD_WR_CAL) begin
            nxt_op    = OP_WR_CAL;
            nxt_state = ST_RECV;
          end
        end
      end
      ST_SEND: begin
        if (!obf_ff) begin
          devPut = 1'b1;
          if (idx_ff == xferLen) begin
            putByte   = XFER_OK_CODE;
            doCommit  = isWriteOp;
            nxt_state = ST_IDLE;
          end else begin
            nxt_idx = idx_ff + 5'h01;
          end
        end
      end
      ST_RECV: begin
        if (ibf_ff) begin
          devTake = 1'b1;
          nxt_idx = idx_ff + 5'h01;
          if (lastRecv) begin
            nxt_state = ST_SEND;
          end
        end
      end
    endcase
    if (doAbort) begin
      nxt_state = ST_IDLE;
      doCommit  = 1'b0;
      devPut    = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      op_ff    <= OP_RD_PRESET;
      chan_ff  <= 2'h0;
      idx_ff   <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      chan_ff  <= nxt_chan;
      idx_ff   <= nxt_idx;
    end
  end

  // Timer restarts on every handshake step, so each byte gets its own window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timer_ff <= 32'h0;
    end else if (!waiting || doAbort) begin
      timer_ff <= 32'h0;
    end else begin
      timer_ff <= timer_ff + 32'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Received data, stored settings and restart
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shadow_ff <= 128'h0;
    end else if (pollHit) begin
      shadow_ff <= 128'h0;
    end else if ((state_ff == ST_RECV) && devTake) begin
      shadow_ff[{idx_ff[3:0], 3'h0} +: 8] <= inLatch_ff;
    end
  end

  // Only a completed transfer commits; an abort leaves stored values intact
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      presetsOut_ff <= PRESET_RST;
      busAddr_ff    <= BUS_ADDR_RST;
      for (int i = 0; i < 4; i++) begin
        calMem_ff[i] <= CAL_RST;
      end
    end else if (doCommit) begin
      unique case (op_ff)
        OP_WR_PRESET: presetsOut_ff     <= shadow_ff;
        OP_WR_CAL:    calMem_ff[chan_ff] <= shadow_ff;
        OP_BUS_ADDR:  busAddr_ff        <= shadow_ff[7:0];
        default:      busAddr_ff        <= busAddr_ff;
      endcase
    end
  end

  // Store request follows the zero byte, one pulse per committed record
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nvmSave_ff    <= 1'b0;
      nvmIsCal_ff   <= 1'b0;
      nvmChan_ff    <= 2'h0;
      restartReq_ff <= 1'b0;
    end else begin
      nvmSave_ff    <= doCommit & (op_ff != OP_BUS_ADDR);
      restartReq_ff <= doAbort | doReset;
      if (doCommit) begin
        nvmIsCal_ff <= (op_ff == OP_WR_CAL);
        nvmChan_ff  <= chan_ff;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Weight computation
  // Calibration is read live, so a write lands in the next computation
  assign measCal = calMem_ff[measChan];

  lcl_weight lcl_weight_inst (
    .clk       (clk),
    .nrst      (nrst),
    .start     (measTick),
    .rawIn     (measRaw),
    .scaleIn   (measCal[CAL_SCALE_LSB +: 32]),
    .gainIn    (measCal[CAL_GAIN_LSB +: 32]),
    .tareIn    (measCal[CAL_TARE_LSB +: 32]),
    .refIn     (measCal[CAL_REF_LSB +: 32]),
    .weight_ff (weightOut),
    .valid_ff  (weightValid)
  );

endmodule // lcl_link

// ---- lcl_link_props.sv ----
/*
  Port-level checker for lcl_link: read-side bus drive, status layout,
  weight timing and the single-cycle pulses.
  Assumes one clock domain and the asynchronous active-low reset nrst.
*/
`timescale 1ns/1ps
module lcl_link_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       ioRdN,
  input wire logic       ioAddr,
  input wire logic [7:0] ioDataOut_ff,
  input wire logic       ioDataOe_ff,
  input wire logic       measTick,
  input wire logic       weightValid,
  input wire logic       nvmSave_ff,
  input wire logic       restartReq_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////////
  // Eight cycles covers the pin synchroniser with margin
  chk_oe_drive: assert property (!ioRdN [*8] |-> ioDataOe_ff)
    else $error("data bus not driven during a read strobe");
  chk_oe_release: assert property (ioRdN [*8] |-> !ioDataOe_ff)
    else $error("data bus still driven after the read strobe");
  chk_status_upper: assert property ((ioAddr && !ioRdN) [*8] |-> ioDataOut_ff[7:2] == 6'h00)
    else $error("status port upper bits not zero");
  chk_weight_delay: assert property (measTick |-> ##2 weightValid)
    else $error("weight result missing two cycles after the tick");
  chk_weight_cause: assert property (weightValid |-> $past(measTick, 2))
    else $error("weight result without a tick");
  chk_save_single: assert property (nvmSave_ff |=> !nvmSave_ff)
    else $error("store request longer than one cycle");
  chk_restart_single: assert property (restartReq_ff |=> !restartReq_ff)
    else $error("restart request longer than one cycle");
  chk_abort_nosave: assert property (restartReq_ff |-> !nvmSave_ff [*4])
    else $error("store request around an abandoned transfer");
endmodule // lcl_link_props

bind lcl_link lcl_link_props lcl_link_props_inst (
  .clk(clk), .nrst(nrst), .ioRdN(ioRdN), .ioAddr(ioAddr), .ioDataOut_ff(ioDataOut_ff),
  .ioDataOe_ff(ioDataOe_ff), .measTick(measTick), .weightValid(weightValid),
  .nvmSave_ff(nvmSave_ff), .restartReq_ff(restartReq_ff)
);

// ---- lcl_host_model.sv ----
/*
  Host PC model: byte reads and writes on the data and status ports.
  Assumes the caller polls the status flags before each data access.
*/
`timescale 1ns/1ps
module lcl_host_model
  import lcl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] ioDataOut_ff,
  output logic            ioWrN,
  output logic            ioRdN,
  output logic            ioAddr,
  output logic      [7:0] ioDataIn
);
  // Idle cycles after a strobe; six or more keeps address and data past the sync delay
  int gap;

  initial begin
    ioWrN = 1'b1;
    ioRdN = 1'b1;
    ioAddr = PORT_DATA;
    ioDataIn = 8'h00;
    gap = 6;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge clk) #1;
    ioAddr = a;
    ioDataIn = d;
    ioWrN = 1'b0;
    repeat (4) @(posedge clk);
    #1 ioWrN = 1'b1;
    repeat (gap) @(posedge clk);
    // Released bus shows the inverse so a stale byte never passes
    #1 ioDataIn = ~d;
  endtask

  task automatic rd(input logic a, output logic [7:0] d);
    @(posedge clk) #1;
    ioAddr = a;
    ioRdN = 1'b0;
    repeat (8) @(posedge clk);
    d = ioDataOut_ff;
    #1 ioRdN = 1'b1;
    repeat (gap) @(posedge clk);
  endtask
endmodule // lcl_host_model

// ---- lcl_link_bench.sv ----
/*
  Self-checking bench for lcl_link driven through the host model.
  Assumes a shortened timeout parameter and default command codes.
*/
`timescale 1ns/1ps
module lcl_link_bench
  import lcl_pkg::*;
;
  localparam int unsigned TO_CYC = 200;
  localparam logic [7:0] RST_CODE = 8'hf0;
  localparam logic [7:0] ADDR_CODE = 8'hf4;
  logic         clk, nrst, ioWrN, ioRdN, ioAddr, ioDataOe_ff, measTick;
  logic         weightValid, nvmSave_ff, nvmIsCal_ff, restartReq_ff;
  logic [7:0]   ioDataIn, ioDataOut_ff, busAddr_ff, addrVal, byteVal;
  logic [1:0]   measChan, nvmChan_ff;
  logic [23:0]  measRaw;
  logic [31:0]  weightOut;
  logic [127:0] presetsOut_ff, presetModel, rec;
  logic [127:0] calModel [4];
  logic [3:0]   calExact;
  logic [32:0]  weightQ [$];
  logic [32:0]  wEnt;
  logic [130:0] saveQ [$];
  logic [130:0] sEnt;
  int           error_cnt, total_checks;

  lcl_link #(.TIMEOUT_CYCLES(TO_CYC), .RESET_CMD(RST_CODE), .ADDR_CMD(ADDR_CODE)) lcl_link_inst (
    .clk(clk), .nrst(nrst), .ioWrN(ioWrN), .ioRdN(ioRdN), .ioAddr(ioAddr),
    .ioDataIn(ioDataIn), .ioDataOut_ff(ioDataOut_ff), .ioDataOe_ff(ioDataOe_ff),
    .measTick(measTick), .measChan(measChan), .measRaw(measRaw), .weightOut(weightOut),
    .weightValid(weightValid), .presetsOut_ff(presetsOut_ff), .busAddr_ff(busAddr_ff),
    .nvmSave_ff(nvmSave_ff), .nvmIsCal_ff(nvmIsCal_ff), .nvmChan_ff(nvmChan_ff),
    .restartReq_ff(restartReq_ff));
  lcl_host_model lcl_host_model_inst (.clk(clk), .ioDataOut_ff(ioDataOut_ff),
    .ioWrN(ioWrN), .ioRdN(ioRdN), .ioAddr(ioAddr), .ioDataIn(ioDataIn));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("Checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic giveUp(input string what);
    error_cnt++;
    $display("Error %s expected completion seen timeout", what);
    summarize();
  endtask

  // Exact only where the Q16.16 scale times gain and raw minus zero both fit in 32 signed bits
  function automatic logic [31:0] weightOf(input logic [127:0] c, input logic [23:0] raw);
    longint p, d;
    p = (longint'($signed(c[CAL_SCALE_LSB +: 32])) * longint'($signed(c[CAL_GAIN_LSB +: 32])));
    p = p >>> FRAC_BITS;
    d = longint'(raw) - (longint'(c[CAL_TARE_LSB +: 32]) - longint'(c[CAL_REF_LSB +: 32]));
    // Pipeline drops the fraction of the final product, so whole units are compared
    return 32'((p * d) >>> FRAC_BITS);
  endfunction

  task automatic tick(input logic [1:0] ch, input logic [23:0] raw);
    @(posedge clk) #1;
    measChan = ch;
    measRaw = raw;
    measTick = 1'b1;
    weightQ.push_back({calExact[ch], weightOf(calModel[ch], raw)});
    @(posedge clk) #1 measTick = 1'b0;
  endtask

  task automatic waitFlag(input int idx, input logic val);
    logic [7:0] s;
    for (int i = 0; i < 60; i++) begin
      lcl_host_model_inst.rd(PORT_STATUS, s);
      if (s[idx] === val) return;
    end
    giveUp("status flag");
  endtask

  task automatic expectStatus(input logic [7:0] e);
    logic [7:0] s;
    lcl_host_model_inst.rd(PORT_STATUS, s);
    check("status port", s, e);
  endtask

  task automatic putByte(input logic [7:0] d);
    waitFlag(IBF_BIT, 1'b0);
    lcl_host_model_inst.wr(PORT_DATA, d);
  endtask

  task automatic getByte(output logic [7:0] d);
    waitFlag(OBF_BIT, 1'b1);
    lcl_host_model_inst.rd(PORT_DATA, d);
  endtask

  task automatic sendCmd(input logic [7:0] c);
    lcl_host_model_inst.gap = 6 + $urandom_range(0, 6);
    putByte(c);
    repeat (8) @(posedge clk);
    expectStatus(8'h01);
    tick(2'($urandom), 24'($urandom));
  endtask

  task automatic readRec(input logic [7:0] c, input logic [127:0] exp);
    logic [7:0] d;
    sendCmd(c);
    for (int i = 0; i < 16; i++) begin
      getByte(d);
      check("record byte", d, exp[8*i +: 8]);
    end
    getByte(d);
    check("read terminator", d, XFER_OK_CODE);
  endtask

  task automatic writeRec(input logic [7:0] c, input logic [127:0] r, input logic isCal);
    logic [7:0] d;
    saveQ.push_back({isCal, c[1:0], r});
    sendCmd(c);
    for (int i = 0; i < 16; i++) putByte(r[8*i +: 8]);
    getByte(d);
    check("write terminator", d, XFER_OK_CODE);
  endtask

  task automatic waitRestart(input int lo, input int hi);
    int n;
    n = 0;
    while (restartReq_ff !== 1'b1) begin
      @(posedge clk) #1;
      n++;
      if (n > hi) giveUp("restart");
    end
    check("restart delay", n >= lo, 1'b1);
  endtask

  // Results are compared in arrival order against the notes left by the driver
  always @(negedge clk) begin
    if (nrst === 1'b1 && weightValid === 1'b1) begin
      if (weightQ.size() == 0) check("weight pulse", 1'b1, 1'b0);
      else begin
        wEnt = weightQ.pop_front();
        if (wEnt[32]) check("weight", weightOut, wEnt[31:0]);
      end
    end
    if (nrst === 1'b1 && nvmSave_ff === 1'b1) begin
      if (saveQ.size() == 0) check("unexpected store", 1'b1, 1'b0);
      else begin
        sEnt = saveQ.pop_front();
        check("store kind", nvmIsCal_ff, sEnt[130]);
        if (sEnt[130]) check("store channel", nvmChan_ff, sEnt[129:128]);
        else check("stored presets", presetsOut_ff, sEnt[127:0]);
      end
    end
  end

  initial begin
    #400000;
    giveUp("run length");
  end

  initial begin
    error_cnt = 0;
    total_checks = 0;
    nrst = 1'b0;
    measTick = 1'b0;
    measChan = 2'h0;
    measRaw = 24'h0;
    presetModel = PRESET_RST;
    calExact = 4'hf;
    for (int i = 0; i < 4; i++) calModel[i] = CAL_RST;
    void'($urandom(32'h8970));
    repeat (10) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (8) @(posedge clk);
    expectStatus(8'h00);
    readRec(CMD_RD_PRESET, presetModel);
    rec = {$urandom, $urandom, $urandom, $urandom};
    writeRec(CMD_WR_PRESET | 8'($urandom_range(1, 3)), rec, 1'b0);
    presetModel = rec;
    readRec(CMD_RD_PRESET, presetModel);
    for (int ch = 0; ch < 4; ch++) begin
      rec = {$urandom, $urandom, $urandom, $urandom};
      writeRec(CMD_WR_CAL + 8'(ch), rec, 1'b1);
      calModel[ch] = rec;
      calExact[ch] = 1'b0;
      readRec(CMD_RD_CAL + 8'(ch), rec);
    end
    // Scale 2.0 and gain 1.5 keep the expected weight free of rounding
    rec = {32'd400, 32'd1000, 32'h0001_8000, 32'h0002_0000};
    writeRec(CMD_WR_CAL + 8'h02, rec, 1'b1);
    calModel[2] = rec;
    calExact[2] = 1'b1;
    repeat (3) tick(2'h2, 24'(600 + $urandom_range(0, 5000)));
    sendCmd(CMD_RD_CAL + 8'h01);
    waitRestart(TO_CYC - 5, TO_CYC + 20);
    expectStatus(8'h00);
    sendCmd(CMD_WR_CAL + 8'h01);
    repeat (5) putByte(8'($urandom));
    waitRestart(TO_CYC - 20, TO_CYC + 30);
    readRec(CMD_RD_CAL + 8'h01, calModel[1]);
    sendCmd(RST_CODE);
    waitRestart(0, 10);
    addrVal = 8'($urandom);
    sendCmd(ADDR_CODE | 8'h02);
    putByte(addrVal);
    getByte(byteVal);
    check("address terminator", byteVal, XFER_OK_CODE);
    check("bus address", busAddr_ff, addrVal);
    repeat (6) @(posedge clk);
    check("pending results", weightQ.size() + saveQ.size(), 0);
    summarize();
  end
endmodule // lcl_link_bench
